// *** hdl/lcc_pkg.sv ***
/*
 * lcc_pkg: constants and types for the lane conditioning register bank,
 * A-side lanes one to three plus the global swing scale.
 * assumes: included before every other lcc file.
 */
package lcc_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int LANES         = 3;
   localparam int REGS_PER_LANE = 5;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_IDLE_RATE_L1 = 8'h32;
   localparam logic [7:0] OFS_EQ_L1        = 8'h33;
   localparam logic [7:0] OFS_SWING_L1     = 8'h34;
   localparam logic [7:0] OFS_DEEMPH_L1    = 8'h35;
   localparam logic [7:0] OFS_THRESH_L1    = 8'h36;
   localparam logic [7:0] OFS_IDLE_RATE_L2 = 8'h39;
   localparam logic [7:0] OFS_EQ_L2        = 8'h3A;
   localparam logic [7:0] OFS_SWING_L2     = 8'h3B;
   localparam logic [7:0] OFS_DEEMPH_L2    = 8'h3C;
   localparam logic [7:0] OFS_THRESH_L2    = 8'h3D;
   localparam logic [7:0] OFS_IDLE_RATE_L3 = 8'h40;
   localparam logic [7:0] OFS_EQ_L3        = 8'h41;
   localparam logic [7:0] OFS_SWING_L3     = 8'h42;
   localparam logic [7:0] OFS_DEEMPH_L3    = 8'h43;
   localparam logic [7:0] OFS_THRESH_L3    = 8'h44;
   localparam logic [7:0] OFS_GLOBAL_SWING = 8'h47;

   // first register of each lane; a lane's five registers are contiguous
   localparam logic [LANES-1:0][7:0] LANE_BASE =
      {OFS_IDLE_RATE_L3, OFS_IDLE_RATE_L2, OFS_IDLE_RATE_L1};
   localparam logic [7:0] LANE_SPAN = 8'h05;

   // register index inside a lane
   localparam logic [2:0] IDX_IDLE_RATE = 3'h0;
   localparam logic [2:0] IDX_EQ        = 3'h1;
   localparam logic [2:0] IDX_SWING     = 3'h2;
   localparam logic [2:0] IDX_DEEMPH    = 3'h3;
   localparam logic [2:0] IDX_THRESH    = 3'h4;

   // ----------------------------------------------------------------
   // reset values and writable bits (reserved bits store nothing)
   // ----------------------------------------------------------------
   localparam logic [7:0] EQ_BYPASS  = 8'h20;
   localparam logic [7:0] SWING_600  = 8'h03;
   localparam logic [7:0] DEEMPH_RST = 8'h03;
   localparam logic [7:0] DEEMPH_0DB = 8'h01;
   localparam logic [7:0] DEEMPH_RSV = 8'hC0;
   localparam logic [7:0] IDLE_RATE_RST = 8'h00;
   localparam logic [7:0] THRESH_RST    = 8'h00;
   localparam logic [7:0] GLOBAL_RST    = 8'h02;

   localparam logic [REGS_PER_LANE-1:0][7:0] LANE_RST =
      {THRESH_RST, DEEMPH_RST, SWING_600, EQ_BYPASS, IDLE_RATE_RST};
   localparam logic [REGS_PER_LANE-1:0][7:0] LANE_MASK =
      {8'h0F, 8'hFF, 8'h3F, 8'h3F, 8'h33};
   localparam logic [7:0] GLOBAL_MASK = 8'h03;

   // equalizer values that match the strap-pin settings
   localparam logic [7:0] EQ_PIN_11 = 8'h2A;
   localparam logic [7:0] EQ_PIN_00 = 8'h30;
   localparam logic [7:0] EQ_PIN_F0 = 8'h32;
   localparam logic [7:0] EQ_PIN_10 = 8'h35;
   localparam logic [7:0] EQ_PIN_01 = 8'h37;
   localparam logic [7:0] EQ_PIN_0F = 8'h3B;
   localparam logic [7:0] EQ_PIN_1F = 8'h3D;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_RATE_SEL  = 0;
   localparam int BIT_RATE_AUTO = 1;
   localparam int BIT_IDLE_SEL  = 4;
   localparam int BIT_IDLE_AUTO = 5;
   localparam int BIT_EQ_EN     = 5;
   localparam int BIT_DE_STYLE  = 7;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       muted;
      logic       rateHigh;
      logic       eqEnable;
      logic [1:0] gainStage;
      logic [2:0] boost;
      logic [5:0] swing;
      logic       deemphStyle;
      logic [6:0] deemphLevel;
      logic [1:0] deassertThr;
      logic [1:0] assertThr;
   } lcc_lane_ctl_t;

   typedef struct packed {
      logic       hit;
      logic       isGlobal;
      logic [1:0] lane;
      logic [2:0] idx;
   } lcc_dec_t;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_ADDR      = 4'b0001,
      ST_ADDR_ACK  = 4'b0010,
      ST_CMD       = 4'b0011,
      ST_CMD_ACK   = 4'b0100,
      ST_WDATA     = 4'b0101,
      ST_WDATA_ACK = 4'b0110,
      ST_RDATA     = 4'b0111,
      ST_RDATA_ACK = 4'b1000
   } lcc_state_t;

   // arbitrary neutral bus address
   localparam logic [6:0] SLAVE_ADDR = 7'h5A;

endpackage

// *** hdl/lcc_pin_sync.sv ***
/*
 * lcc_pin_sync: three-stage synchroniser for asynchronous pins; an
 * output changes only when the second and third stages agree.
 * assumes: inputs are static for at least two core_clk periods.
 */
`timescale 1ns/10ps
module lcc_pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] levelOut
);

   logic [WIDTH-1:0] stage1Q;
   logic [WIDTH-1:0] stage2Q;
   logic [WIDTH-1:0] stage3Q;
   logic [WIDTH-1:0] agreeD;

   assign agreeD = (stage2Q == stage3Q) ? stage3Q : levelOut;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage1Q  <= RESET_VAL;
         stage2Q  <= RESET_VAL;
         stage3Q  <= RESET_VAL;
         levelOut <= RESET_VAL;
      end
      else
      begin
         stage1Q  <= pinIn;
         stage2Q  <= stage1Q;
         stage3Q  <= stage2Q;
         levelOut <= agreeD;
      end
   end

endmodule

// *** hdl/lcc_config_regs.sv ***
/*
 * lcc_config_regs: lane conditioning configuration bank with its serial
 * management slave (byte write, random and sequential read).
 * assumes: open-drain data line resolved outside; clock line driven only
 * by the host; detector inputs are asynchronous to core_clk.
 */
`timescale 1ns/10ps
module lcc_config_regs (
   input  wire logic                           core_clk,
   input  wire logic                           arst_n,
   input  wire logic                           smbClk,
   input  wire logic                           smbDataIn,
   output logic                                smbDataOut,
   output logic                                smbDataOe,
   input  wire logic [lcc_pkg::LANES-1:0]      idleDetect,
   input  wire logic [lcc_pkg::LANES-1:0]      rateDetectHigh,
   output lcc_pkg::lcc_lane_ctl_t [lcc_pkg::LANES-1:0] laneCtl,
   output logic [1:0]                          globalSwingScale
);
   import lcc_pkg::*;

   // ----------------------------------------------------------------
   // address decode shared by reads and writes
   // ----------------------------------------------------------------
   function automatic lcc_dec_t decodeAddr(input logic [7:0] addr);
      lcc_dec_t   dec;
      logic [7:0] offs;
      dec  = '0;
      offs = '0;
      if (addr == OFS_GLOBAL_SWING)
      begin
         dec.hit      = 1'b1;
         dec.isGlobal = 1'b1;
      end
      for (int l = 0; l < LANES; l++)
      begin
         offs = 8'(addr - LANE_BASE[l]);
         if (offs < LANE_SPAN)
         begin
            dec.hit  = 1'b1;
            dec.lane = 2'(l);
            dec.idx  = 3'(offs);
         end
      end
      return dec;
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [7:0] pinRaw;
   logic [7:0] pinLevel;
   logic       sclQ;
   logic       sdaQ;
   logic [LANES-1:0] idleSync;
   logic [LANES-1:0] rateSync;

   assign pinRaw = {rateDetectHigh, idleDetect, smbDataIn, smbClk};

   lcc_pin_sync #(
      .WIDTH     (8),
      .RESET_VAL (8'h03)
   ) pinSync (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .pinIn    (pinRaw),
      .levelOut (pinLevel)
   );

   assign sclQ     = pinLevel[0];
   assign sdaQ     = pinLevel[1];
   assign idleSync = pinLevel[4:2];
   assign rateSync = pinLevel[7:5];

   // ----------------------------------------------------------------
   // bus conditions
   // ----------------------------------------------------------------
   logic sclPrevQ;
   logic sdaPrevQ;
   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;

   assign sclRise   = sclQ & ~sclPrevQ;
   assign sclFall   = ~sclQ & sclPrevQ;
   assign startCond = sclQ & sclPrevQ & sdaPrevQ & ~sdaQ;
   assign stopCond  = sclQ & sclPrevQ & ~sdaPrevQ & sdaQ;

   // ----------------------------------------------------------------
   // slave state machine
   // ----------------------------------------------------------------
   lcc_state_t stateQ;
   lcc_state_t stateD;
   logic [3:0] bitCntQ;
   logic [3:0] bitCntD;
   logic [7:0] shiftQ;
   logic [7:0] shiftD;
   logic [7:0] txQ;
   logic [7:0] txD;
   logic [7:0] ptrQ;
   logic [7:0] ptrD;
   logic       rwQ;
   logic       rwD;
   logic       ackedQ;
   logic       ackedD;
   logic       oeQ;
   logic       oeD;
   logic       wrEn;
   logic [7:0] rdByte;
   logic [7:0] globalQ;
   logic [7:0] regQ [LANES][REGS_PER_LANE];
   lcc_dec_t   rdDec;
   lcc_dec_t   wrDec;
   logic       byteDone;

   assign byteDone = (bitCntQ == 4'h8);
   assign rdDec    = decodeAddr(ptrQ);
   assign wrDec    = decodeAddr(ptrQ);
   // unmapped reads return zero
   assign rdByte   = !rdDec.hit    ? 8'h00 :
                     rdDec.isGlobal ? globalQ :
                                      regQ[rdDec.lane][rdDec.idx];

   always_comb
   begin
      stateD  = stateQ;
      bitCntD = bitCntQ;
      shiftD  = shiftQ;
      txD     = txQ;
      ptrD    = ptrQ;
      rwD     = rwQ;
      ackedD  = ackedQ;
      oeD     = oeQ;
      wrEn    = 1'b0;
      if (startCond)
      begin
         stateD  = ST_ADDR;
         bitCntD = 4'h0;
         oeD     = 1'b0;
      end
      else if (stopCond)
      begin
         stateD = ST_IDLE;
         oeD    = 1'b0;
      end
      else if (sclRise)
      begin
         case (stateQ)
            ST_ADDR, ST_CMD, ST_WDATA:
            begin
               shiftD  = {shiftQ[6:0], sdaQ};
               bitCntD = 4'(bitCntQ + 4'h1);
            end
            ST_RDATA_ACK: ackedD = ~sdaQ;
            default: ;
         endcase
      end
      else if (sclFall)
      begin
         case (stateQ)
            ST_ADDR:
               if (byteDone)
               begin
                  if (shiftQ[7:1] == SLAVE_ADDR)
                  begin
                     rwD    = shiftQ[0];
                     oeD    = 1'b1;
                     stateD = ST_ADDR_ACK;
                  end
                  else
                     stateD = ST_IDLE;
               end
            ST_ADDR_ACK:
               if (rwQ)
               begin
                  txD     = rdByte;
                  oeD     = ~rdByte[7];
                  bitCntD = 4'h1;
                  stateD  = ST_RDATA;
               end
               else
               begin
                  oeD     = 1'b0;
                  bitCntD = 4'h0;
                  stateD  = ST_CMD;
               end
            ST_CMD:
               if (byteDone)
               begin
                  ptrD   = shiftQ;
                  oeD    = 1'b1;
                  stateD = ST_CMD_ACK;
               end
            ST_CMD_ACK:
            begin
               oeD     = 1'b0;
               bitCntD = 4'h0;
               stateD  = ST_WDATA;
            end
            ST_WDATA:
               if (byteDone)
               begin
                  wrEn   = 1'b1;
                  oeD    = 1'b1;
                  stateD = ST_WDATA_ACK;
               end
            ST_WDATA_ACK:
            begin
               oeD     = 1'b0;
               bitCntD = 4'h0;
               ptrD    = 8'(ptrQ + 8'h01);
               stateD  = ST_WDATA;
            end
            ST_RDATA:
               if (byteDone)
               begin
                  oeD    = 1'b0;
                  ptrD   = 8'(ptrQ + 8'h01);
                  stateD = ST_RDATA_ACK;
               end
               else
               begin
                  txD     = {txQ[6:0], 1'b0};
                  oeD     = ~txQ[6];
                  bitCntD = 4'(bitCntQ + 4'h1);
               end
            ST_RDATA_ACK:
               if (ackedQ)
               begin
                  txD     = rdByte;
                  oeD     = ~rdByte[7];
                  bitCntD = 4'h1;
                  stateD  = ST_RDATA;
               end
               else
               begin
                  oeD    = 1'b0;
                  stateD = ST_IDLE;
               end
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stateQ   <= ST_IDLE;
         bitCntQ  <= 4'h0;
         shiftQ   <= 8'h00;
         txQ      <= 8'h00;
         ptrQ     <= 8'h00;
         rwQ      <= 1'b0;
         ackedQ   <= 1'b0;
         oeQ      <= 1'b0;
         sclPrevQ <= 1'b1;
         sdaPrevQ <= 1'b1;
      end
      else
      begin
         stateQ   <= stateD;
         bitCntQ  <= bitCntD;
         shiftQ   <= shiftD;
         txQ      <= txD;
         ptrQ     <= ptrD;
         rwQ      <= rwD;
         ackedQ   <= ackedD;
         oeQ      <= oeD;
         sclPrevQ <= sclQ;
         sdaPrevQ <= sdaQ;
      end
   end

   // open drain: only ever pulls low
   assign smbDataOut = 1'b0;
   assign smbDataOe  = oeQ;

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         globalQ <= GLOBAL_RST;
      else if (wrEn && wrDec.hit && wrDec.isGlobal)
         globalQ <= shiftQ & GLOBAL_MASK;
   end

   for (genvar l = 0; l < LANES; l++)
   begin : g_lane
      for (genvar r = 0; r < REGS_PER_LANE; r++)
      begin : g_reg
         logic wrHit;
         assign wrHit = wrEn && wrDec.hit && !wrDec.isGlobal &&
                        (wrDec.lane == 2'(l)) && (wrDec.idx == 3'(r));
         // reset values give bypassed equalizer and 600 mV swing
         always_ff @(posedge core_clk or negedge arst_n)
         begin
            if (!arst_n)
               regQ[l][r] <= LANE_RST[r];
            else if (wrHit)
               regQ[l][r] <= shiftQ & LANE_MASK[r];
         end
      end
   end

   // ----------------------------------------------------------------
   // lane controls
   // ----------------------------------------------------------------
   lcc_lane_ctl_t [LANES-1:0] laneCtlD;

   for (genvar l = 0; l < LANES; l++)
   begin : g_ctl
      logic [7:0] idleRate;
      logic [7:0] eqReg;
      logic [7:0] deReg;
      logic [7:0] deApplied;
      assign idleRate = regQ[l][IDX_IDLE_RATE];
      assign eqReg    = regQ[l][IDX_EQ];
      assign deReg    = regQ[l][IDX_DEEMPH];
      // reserved level code falls back to 0 dB
      assign deApplied = (deReg == DEEMPH_RSV) ? DEEMPH_0DB : deReg;

      assign laneCtlD[l].muted = idleRate[BIT_IDLE_AUTO] ?
                                 idleSync[l] :
                                 idleRate[BIT_IDLE_SEL];
      assign laneCtlD[l].rateHigh = idleRate[BIT_RATE_AUTO] ?
                                    rateSync[l] :
                                    idleRate[BIT_RATE_SEL];
      assign laneCtlD[l].eqEnable    = eqReg[BIT_EQ_EN];
      assign laneCtlD[l].gainStage   = eqReg[4:3];
      assign laneCtlD[l].boost       = eqReg[2:0];
      assign laneCtlD[l].swing       = regQ[l][IDX_SWING][5:0];
      assign laneCtlD[l].deemphStyle = deApplied[BIT_DE_STYLE];
      assign laneCtlD[l].deemphLevel = deApplied[6:0];
      assign laneCtlD[l].deassertThr = regQ[l][IDX_THRESH][3:2];
      assign laneCtlD[l].assertThr   = regQ[l][IDX_THRESH][1:0];
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         laneCtl          <= '0;
         globalSwingScale <= GLOBAL_RST[1:0];
      end
      else
      begin
         laneCtl          <= laneCtlD;
         globalSwingScale <= globalQ[1:0];
      end
   end

endmodule

// *** tb/lcc_config_regs_monitor.sv ***
/* lcc_config_regs_monitor: port assertions for lcc_config_regs.
   assumes: bound to the design; one clock domain. */
`timescale 1ns/10ps
module lcc_config_regs_monitor
   import lcc_pkg::*;
(
   input wire logic                 core_clk,
   input wire logic                 arst_n,
   input wire logic                 smbClk,
   input wire logic                 smbDataIn,
   input wire logic                 smbDataOut,
   input wire logic                 smbDataOe,
   input wire logic [LANES-1:0]     idleDetect,
   input wire logic [LANES-1:0]     rateDetectHigh,
   input lcc_lane_ctl_t [LANES-1:0] laneCtl,
   input wire logic [1:0]           globalSwingScale
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   sequence relSeq;
      $rose(arst_n);
   endsequence

   // settled: reset released at least three edges back
   sequence settledSeq;
      $past(arst_n, 3);
   endsequence

   for (genvar i = 0; i < LANES; i++)
   begin : g_lane
      eq_reset_a: assert property (relSeq |-> ##1
         ({laneCtl[i].eqEnable, laneCtl[i].gainStage,
           laneCtl[i].boost} == 6'h20))
         else $error("equalizer reset value wrong");
      swing_reset_a: assert property (relSeq |-> ##1
         (laneCtl[i].swing == 6'h03))
         else $error("swing reset value wrong");
      thr_reset_a: assert property (relSeq |-> ##1
         ({laneCtl[i].deassertThr, laneCtl[i].assertThr} == 4'h0))
         else $error("threshold reset value wrong");
      deemph_rsv_a: assert property (!(laneCtl[i].deemphStyle &&
         laneCtl[i].deemphLevel == 7'h40))
         else $error("reserved de-emphasis code applied");
      cfg_hold_a: assert property ($changed(laneCtl[i][23:0])
         ##0 settledSeq |-> !smbClk)
         else $error("lane settings moved outside a bus write");
      mute_source_a: assert property ($changed(laneCtl[i].muted)
         ##0 settledSeq |-> (!smbClk ||
         laneCtl[i].muted == idleDetect[i]))
         else $error("mute changed without cause");
      rate_source_a: assert property ($changed(laneCtl[i].rateHigh)
         ##0 settledSeq |-> (!smbClk ||
         laneCtl[i].rateHigh == rateDetectHigh[i]))
         else $error("rate changed without cause");
   end

   global_reset_a: assert property (relSeq |-> ##1
      globalSwingScale == 2'b10)
      else $error("global swing reset value wrong");
   global_hold_a: assert property ($changed(globalSwingScale)
      ##0 settledSeq |-> !smbClk)
      else $error("global swing moved outside a bus write");
   ack_phase_a: assert property ($rose(smbDataOe) |-> !smbClk)
      else $error("data line pulled while clock high");
endmodule

bind lcc_config_regs lcc_config_regs_monitor u_mon (
   .core_clk(core_clk), .arst_n(arst_n), .smbClk(smbClk),
   .smbDataIn(smbDataIn), .smbDataOut(smbDataOut),
   .smbDataOe(smbDataOe), .idleDetect(idleDetect),
   .rateDetectHigh(rateDetectHigh), .laneCtl(laneCtl),
   .globalSwingScale(globalSwingScale));

// *** tb/lcc_smb_host.sv ***
/* lcc_smb_host: management bus host model clocked by core_clk.
   assumes: the bench resolves the data line with a pull-up. */
`timescale 1ns/10ps
module lcc_smb_host (
   input  wire logic core_clk,
   input  wire logic sdaLine,
   output logic      sclOut,
   output logic      sdaLow
);
   // bus phases of ten clocks, twice the minimum
   localparam int PH = 10;

   initial
   begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end

   task automatic waitClk(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // start or repeated start; ends with clock just lowered
   task automatic startCond();
      waitClk(PH / 2);
      sdaLow = 1'b0;
      waitClk(PH / 2);
      sclOut = 1'b1;
      waitClk(PH);
      sdaLow = 1'b1;
      waitClk(PH);
      sclOut = 1'b0;
   endtask

   task automatic stopCond();
      waitClk(PH / 2);
      sdaLow = 1'b1;
      waitClk(PH / 2);
      sclOut = 1'b1;
      waitClk(PH);
      sdaLow = 1'b0;
      waitClk(PH);
   endtask

   // data set mid-low, sampled at end of high phase
   task automatic xferBit(input logic b, output logic r);
      waitClk(PH / 2);
      sdaLow = !b;
      waitClk(PH / 2);
      sclOut = 1'b1;
      waitClk(PH);
      r = sdaLine;
      sclOut = 1'b0;
   endtask

   task automatic xferByte(input logic [7:0] tx, input logic ackIn,
                           output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--)
         xferBit(tx[i], rx[i]);
      xferBit(ackIn, ack);
   endtask
endmodule

// *** tb/test_lane_conditioning_config_regs.sv ***
/* test_lane_conditioning_config_regs: bench for lcc_config_regs.
   assumes: host model and monitor compiled before this file. */
`timescale 1ns/10ps
module test_lane_conditioning_config_regs;
   import lcc_pkg::*;

   logic                      core_clk = 1'b0;
   logic                      arst_n;
   logic                      smbClk;
   logic                      sdaLow;
   logic                      sdaLine;
   logic                      smbDataOut;
   logic                      smbDataOe;
   logic [LANES-1:0]          idleDetect;
   logic [LANES-1:0]          rateDetectHigh;
   lcc_lane_ctl_t [LANES-1:0] laneCtl;
   logic [1:0]                globalSwingScale;
   logic [7:0]                rd;
   logic                      ack;
   int                        n_mismatch;
   int                        total_checks;
   int                        cycles = 0;

   localparam logic [7:0] RST_T [5] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00};
   localparam logic [7:0] MSK_T [5] = '{8'h33, 8'h3F, 8'h3F, 8'hFF, 8'h0F};
   // reserved bits set on purpose
   localparam logic [7:0] WR_T  [5] = '{8'hD1, 8'hF5, 8'hDF, 8'hE8, 8'hFB};
   localparam logic [7:0] DE_T  [6] =
      '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0, 8'hC0};

   // open-drain data line with pull-up
   assign sdaLine = !(sdaLow || (smbDataOe && !smbDataOut));

   lcc_smb_host host (.core_clk(core_clk), .sdaLine(sdaLine),
      .sclOut(smbClk), .sdaLow(sdaLow));
   lcc_config_regs DUT (.core_clk(core_clk), .arst_n(arst_n),
      .smbClk(smbClk), .smbDataIn(sdaLine), .smbDataOut(smbDataOut),
      .smbDataOe(smbDataOe), .idleDetect(idleDetect),
      .rateDetectHigh(rateDetectHigh), .laneCtl(laneCtl),
      .globalSwingScale(globalSwingScale));

   always #50 core_clk = ~core_clk;

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [7:0] ofsOf(input int i);
      return (i < 15) ? 8'(8'h32 + 7 * (i / 5) + i % 5) : 8'h47;
   endfunction

   // outputs of register i laid out as the register, except idle rate: mute in bit 1, rate in bit 0
   function automatic logic [7:0] viewOf(input int i);
      lcc_lane_ctl_t c;
      if (i == 15)
         return {6'h00, globalSwingScale};
      c = laneCtl[i / 5];
      case (i % 5)
         0: return {6'h00, c.muted, c.rateHigh};
         1: return {2'h0, c.eqEnable, c.gainStage, c.boost};
         2: return {2'h0, c.swing};
         3: return {c.deemphStyle, c.deemphLevel};
         default: return {4'h0, c.deassertThr, c.assertThr};
      endcase
   endfunction

   // expected outputs for stored value v, manual mode
   function automatic logic [7:0] expView(input int i, input logic [7:0] v);
      if (i < 15 && i % 5 == 0)
         return {6'h00, v[4], v[0]};
      if (i < 15 && i % 5 == 3 && v == 8'hC0)
         return 8'h01;
      return v;
   endfunction

   task automatic regWrite(input logic [7:0] ofs, input logic [7:0] v);
      logic [7:0] rx;
      logic [2:0] a;
      host.startCond();
      host.xferByte({SLAVE_ADDR, 1'b0}, 1'b1, rx, a[2]);
      host.xferByte(ofs, 1'b1, rx, a[1]);
      host.xferByte(v, 1'b1, rx, a[0]);
      host.stopCond();
      check("write ack", {5'h00, a}, 8'h00);
   endtask

   task automatic regRead(input logic [7:0] ofs, output logic [7:0] v);
      logic [7:0] rx;
      logic [2:0] a;
      host.startCond();
      host.xferByte({SLAVE_ADDR, 1'b0}, 1'b1, rx, a[2]);
      host.xferByte(ofs, 1'b1, rx, a[1]);
      host.startCond();
      host.xferByte({SLAVE_ADDR, 1'b1}, 1'b1, rx, a[0]);
      host.xferByte(8'hFF, 1'b1, v, ack);
      host.stopCond();
      check("read ack", {5'h00, a}, 8'h00);
   endtask

   task automatic wrCheck(input int i, input logic [7:0] v);
      logic [7:0] m;
      m = (i < 15) ? MSK_T[i % 5] : 8'h03;
      regWrite(ofsOf(i), v);
      regRead(ofsOf(i), rd);
      check("readback", rd, v & m);
      check("outputs", viewOf(i), expView(i, v & m));
   endtask

   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         n_mismatch++;
         final_report();
      end
   end

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial
   begin
      arst_n = 1'b0;
      idleDetect = '0;
      rateDetectHigh = '0;
      n_mismatch = 0;
      total_checks = 0;
      repeat (5) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (5) @(negedge core_clk);
      for (int i = 0; i < 16; i++)
      begin
         regRead(ofsOf(i), rd);
         check("reset", rd, (i < 15) ? RST_T[i % 5] : 8'h02);
         check("reset out", viewOf(i),
               expView(i, (i < 15) ? RST_T[i % 5] : 8'h02));
      end
      for (int i = 0; i < 16; i++)
         wrCheck(i, (i < 15) ? WR_T[i % 5] : 8'hFD);
      for (int c = 0; c < 4; c++)
         wrCheck(15, 8'(c));
      for (int c = 0; c < 4; c++)
         wrCheck(4, 8'(4 * c + 3 - c));
      for (int j = 0; j < 6; j++)
         wrCheck(13, DE_T[j]);
      wrCheck(5, 8'h22);
      idleDetect = '1;
      rateDetectHigh = '1;
      repeat (10) @(negedge core_clk);
      check("auto on", viewOf(5), 8'h03);
      idleDetect = '0;
      rateDetectHigh = '0;
      repeat (10) @(negedge core_clk);
      check("auto off", viewOf(5), 8'h00);
      check("manual kept", viewOf(10), 8'h03);
      wrCheck(5, 8'h00);
      host.startCond();
      host.xferByte({SLAVE_ADDR, 1'b0}, 1'b1, rd, ack);
      host.xferByte(8'h41, 1'b1, rd, ack);
      host.xferByte(8'h2A, 1'b1, rd, ack);
      host.xferByte(8'h07, 1'b1, rd, ack);
      host.stopCond();
      check("burst eq", viewOf(11), 8'h2A);
      check("burst swing", viewOf(12), 8'h07);
      // sequential read: acknowledge first byte, refuse second
      host.startCond();
      host.xferByte({SLAVE_ADDR, 1'b0}, 1'b1, rd, ack);
      host.xferByte(8'h41, 1'b1, rd, ack);
      host.startCond();
      host.xferByte({SLAVE_ADDR, 1'b1}, 1'b1, rd, ack);
      host.xferByte(8'hFF, 1'b0, rd, ack);
      check("burst read eq", rd, 8'h2A);
      host.xferByte(8'hFF, 1'b1, rd, ack);
      host.stopCond();
      check("burst read swing", rd, 8'h07);
      host.startCond();
      host.xferByte({7'h2D, 1'b0}, 1'b1, rd, ack);
      host.stopCond();
      check("foreign address", {7'h00, ack}, 8'h01);
      regWrite(8'h37, 8'hA5);
      regRead(8'h37, rd);
      check("unmapped", rd, 8'h00);
      final_report();
   end
endmodule
